//--- src/ues_ep_status.sv
// module: endpoint event flags, transfer sizes, fifo space, phy clock gate
`timescale 1ns/1ps
module ues_ep_status
  import ues_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  input  wire ues_in_ev_s  [7:0] IN_EV,
  input  wire ues_out_ev_s [7:0] OUT_EV,
  input  wire logic [7:0]        EP_ENABLED,
  input  wire logic [7:0]        EP_STALL,
  input  wire logic [7:0]        CLEAR_NAK,
  input  wire logic [7:0]        CTRL_EP,
  input  wire logic [7:0][15:0]  FIFO_FREE,
  input  wire logic [18:0]       PKT_BYTES,
  input  wire logic              PHY_SUSPENDED,
  output logic [7:0]             BYTE_ZERO_IN,
  output logic [7:0]             BYTE_ZERO_OUT,
  output logic [7:0][1:0]        PACKETS_PER_FRAME,
  output logic                   STOP_PHY_CLOCK,
  output logic                   GLOBAL_IN_EVENT,
  output logic                   GLOBAL_OUT_EVENT
);
  localparam int FIFO_HALF = 256;

  logic [7:0][7:0]  in_flag_r;
  logic [7:0][7:0]  out_flag_r;
  logic [7:0][2:0]  setup_run_r;
  logic [7:0][1:0]  ppf_r;
  logic [7:0][1:0]  setup_cnt_r;
  logic [7:0][1:0]  pid_r;
  logic [7:0][15:0] free_r;
  logic [7:0][31:0] insize_rd;
  logic [7:0][31:0] outsize_rd;
  logic [7:0]       txfe;
  logic [7:0]       summary_in;
  logic [7:0]       summary_out;
  logic             empty_level_r;
  logic             stop_clk_r;
  logic [31:0]      rdata_r;
  logic [2:0]       ep;

  assign ep = ADDR[2:0];

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      localparam int PW = (g == 0) ? 2 : 10;
      localparam int BW = (g == 0) ? 7 : 19;
      localparam int OPW = (g == 0) ? 1 : 10;
      logic [PW-1:0]  ipkt;
      logic [BW-1:0]  ibyte;
      logic [OPW-1:0] opkt;
      logic [BW-1:0]  obyte;
      logic           wr_in_sz;
      logic           wr_out_sz;
      logic [7:0]     in_set;
      logic [7:0]     out_set;
      logic [7:0]     in_clr;
      logic [7:0]     out_clr;

      // size writes are only honoured while the endpoint is idle
      assign wr_in_sz  = WR && ADDR == REG_INSIZE + 8'(g)
                         && !EP_ENABLED[g];
      assign wr_out_sz = WR && ADDR == REG_OUTSIZE + 8'(g)
                         && !EP_ENABLED[g];

      ues_size_cnt #(.PW(PW), .BW(BW)) u_in (
        .CLK       (CLK),
        .RST       (RST),
        .wr_en     (wr_in_sz),
        .wr_data   (WDATA),
        .pkt_dec   (IN_EV[g].pkt_from_fifo),
        .byte_dec  (IN_EV[g].pkt_to_fifo),
        .pkt_bytes (PKT_BYTES[BW-1:0]),
        .pkt_cnt   (ipkt),
        .byte_cnt  (ibyte),
        .byte_zero (BYTE_ZERO_IN[g])
      );
      ues_size_cnt #(.PW(OPW), .BW(BW)) u_out (
        .CLK       (CLK),
        .RST       (RST),
        .wr_en     (wr_out_sz),
        .wr_data   (WDATA),
        .pkt_dec   (OUT_EV[g].pkt_to_fifo),
        .byte_dec  (OUT_EV[g].pkt_from_fifo),
        .pkt_bytes (PKT_BYTES[BW-1:0]),
        .pkt_cnt   (opkt),
        .byte_cnt  (obyte),
        .byte_zero (BYTE_ZERO_OUT[g])
      );

      // low fifo level selects half empty, high level completely empty
      assign txfe[g] = empty_level_r ? (free_r[g] == FREE_RESET)
                                     : (free_r[g] >= 16'(FIFO_HALF));

      always_comb begin
        in_set = '0;
        in_set[B_NAKEFF]   = IN_EV[g].nak_effect && EP_ENABLED[g]
                             && !EP_STALL[g];
        in_set[B_TOKEMPTY] = IN_EV[g].in_tok_empty;
        in_set[B_TIMEOUT]  = IN_EV[g].timeout && CTRL_EP[g];
        in_set[B_EPDIS]    = IN_EV[g].disabled;
        in_set[B_XFERDONE] = IN_EV[g].xfer_done;
        out_set = '0;
        // every setup past the third flags, also once the run saturates
        out_set[B_B2B]       = OUT_EV[g].setup_rx
                               && setup_run_r[g] >= 3'h3;
        out_set[B_OUTDIS]    = OUT_EV[g].out_tok_dis && CTRL_EP[g]
                               && !EP_ENABLED[g];
        out_set[B_SETUPDONE] = OUT_EV[g].setup_end && CTRL_EP[g];
        out_set[B_EPDIS]     = OUT_EV[g].disabled;
        out_set[B_XFERDONE]  = OUT_EV[g].xfer_done;
        in_clr  = (WR && ADDR == REG_INFLAG + 8'(g)) ? WDATA[7:0] : '0;
        in_clr[B_TXFE] = 1'b0;
        in_clr[B_NAKEFF] = in_clr[B_NAKEFF] | CLEAR_NAK[g];
        out_clr = (WR && ADDR == REG_OUTFLAG + 8'(g)) ? WDATA[7:0] : '0;
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          in_flag_r[g]  <= '0;
          out_flag_r[g] <= '0;
        end else begin
          in_flag_r[g]  <= (in_flag_r[g] & ~in_clr) | in_set;
          out_flag_r[g] <= (out_flag_r[g] & ~out_clr) | out_set;
        end
      end

      // consecutive setups; cleared by any other packet or setup end
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          setup_run_r[g] <= '0;
        end else if (OUT_EV[g].setup_rx) begin
          if (setup_run_r[g] != 3'h4)
            setup_run_r[g] <= setup_run_r[g] + 3'h1;
        end else if (OUT_EV[g].setup_end || OUT_EV[g].pkt_to_fifo) begin
          setup_run_r[g] <= '0;
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          ppf_r[g]       <= '0;
          setup_cnt_r[g] <= '0;
          pid_r[g]       <= '0;
          free_r[g]      <= FREE_RESET;
        end else begin
          // endpoint 0 has no multi-count field, its bits stay reserved
          if (wr_in_sz && g != 0)
            ppf_r[g] <= WDATA[30:29];
          if (wr_out_sz)
            setup_cnt_r[g] <= WDATA[30:29];
          else if (OUT_EV[g].setup_rx && setup_cnt_r[g] != 2'h0)
            setup_cnt_r[g] <= setup_cnt_r[g] - 2'h1;
          if (OUT_EV[g].pkt_to_fifo && !CTRL_EP[g])
            pid_r[g] <= OUT_EV[g].pid;
          free_r[g] <= FIFO_FREE[g];
        end
      end

      always_comb begin
        insize_rd[g]  = '0;
        outsize_rd[g] = '0;
        insize_rd[g][19 +: PW]   = ipkt;
        insize_rd[g][BW-1:0]     = ibyte;
        outsize_rd[g][19 +: OPW] = opkt;
        outsize_rd[g][BW-1:0]    = obyte;
        if (g == 0)
          outsize_rd[g][30:29] = setup_cnt_r[g];
        else
          outsize_rd[g][30:29] = pid_r[g];
        if (g != 0)
          insize_rd[g][30:29] = ppf_r[g];
      end

      assign summary_in[g]  = |in_flag_r[g];
      assign summary_out[g] = |out_flag_r[g];
      assign PACKETS_PER_FRAME[g] = ppf_r[g];

      chk_b2b_fourth: assert property (@(posedge CLK) disable iff (RST)
        (OUT_EV[g].setup_rx [*4]) |=> out_flag_r[g][B_B2B])
        else $error("fourth back-to-back setup not flagged");
      chk_timeout_ctrl: assert property (@(posedge CLK) disable iff (RST)
        (IN_EV[g].timeout && !CTRL_EP[g] && !in_flag_r[g][B_TIMEOUT])
        |=> !in_flag_r[g][B_TIMEOUT])
        else $error("timeout flagged on non-control endpoint");
      chk_nak_stall: assert property (@(posedge CLK) disable iff (RST)
        (IN_EV[g].nak_effect && EP_ENABLED[g] && !EP_STALL[g])
        |=> in_flag_r[g][B_NAKEFF])
        else $error("nak effective not raised");
      chk_set_wins: assert property (@(posedge CLK) disable iff (RST)
        OUT_EV[g].xfer_done |=> out_flag_r[g][B_XFERDONE])
        else $error("transfer complete lost");
    end
  endgenerate

  // control bits take the written value; the empty flag is live and not writable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      empty_level_r <= 1'b0;
      stop_clk_r    <= 1'b0;
    end else if (WR && ADDR == REG_CTRL) begin
      empty_level_r <= WDATA[0];
    end else if (WR && ADDR == REG_PHYCLK) begin
      stop_clk_r <= WDATA[B_STOPCLK];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= '0;
    end else if (RD) begin
      rdata_r <= '0;
      if (ADDR[7:3] == REG_INFLAG[7:3]) begin
        rdata_r[7:0]    <= in_flag_r[ep];
        rdata_r[B_TXFE] <= txfe[ep];
      end else if (ADDR[7:3] == REG_OUTFLAG[7:3])
        rdata_r[7:0] <= out_flag_r[ep];
      else if (ADDR[7:3] == REG_INSIZE[7:3])
        rdata_r <= insize_rd[ep];
      else if (ADDR[7:3] == REG_OUTSIZE[7:3])
        rdata_r <= outsize_rd[ep];
      else if (ADDR[7:3] == REG_FREE[7:3])
        rdata_r[15:0] <= free_r[ep];
      else if (ADDR == REG_SUMMARY)
        rdata_r <= {8'h00, summary_out, 8'h00, summary_in};
      else if (ADDR == REG_CTRL)
        rdata_r[0] <= empty_level_r;
      else if (ADDR == REG_PHYCLK) begin
        rdata_r[B_STOPCLK] <= stop_clk_r;
        rdata_r[B_SUSP]    <= PHY_SUSPENDED;
      end else if (ADDR == REG_GLOBAL)
        rdata_r[1:0] <= {|summary_out, |summary_in};
    end
  end

  assign RDATA            = rdata_r;
  assign STOP_PHY_CLOCK   = stop_clk_r;
  assign GLOBAL_IN_EVENT  = |summary_in;
  assign GLOBAL_OUT_EVENT = |summary_out;

  chk_stop_clock_wr: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == REG_PHYCLK) |=> STOP_PHY_CLOCK == $past(WDATA[0]))
    else $error("stop clock not taken");
  chk_summary_or: assert property (@(posedge CLK) disable iff (RST)
    GLOBAL_OUT_EVENT == (out_flag_r != '0))
    else $error("summary not or of flags");
  chk_w1c_clear: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == REG_OUTFLAG && WDATA[0] && !OUT_EV[0].xfer_done)
    |=> !out_flag_r[0][B_XFERDONE])
    else $error("write one did not clear");
endmodule : ues_ep_status

//--- src/ues_pkg.sv
// package: register map, field layout and event types for endpoint status
// How it works
// - fifo empty flag follows selected threshold
// - nak effective set on effect, clear-nak clears
// - in token with empty fifo sets flag
// - timeout flag only on control in
// - disabled flag set in in and out
// - transfer complete flag set per side on that side's done
// - flags clear by writing one, summary follows
// - more than three setups sets back-to-back flag
// - out token while disabled, control only
// - setup done when setup stage ends
// - sizes programmed before enable, then read-only
// - ep0 in counts packets and bytes down
// - setup packet count encodes one to three
// - ep0 out packet bit and bytes count down
// - packets per frame sets iso in pid
// - ep1-7 in counts packets and bytes down
// - fifo free words, reset 0x200
// - last received pid recorded for iso out
// - ep1-7 out counts packets and bytes down
// - stop phy clock bit gates phy clock
// - phy suspended reads one while suspended
package ues_pkg;
  localparam int          NUM_EP       = 8;
  localparam logic [7:0]  REG_INFLAG   = 8'h00; // + ep
  localparam logic [7:0]  REG_OUTFLAG  = 8'h08; // + ep
  localparam logic [7:0]  REG_INSIZE   = 8'h10; // + ep
  localparam logic [7:0]  REG_OUTSIZE  = 8'h18; // + ep
  localparam logic [7:0]  REG_FREE     = 8'h20; // + ep
  localparam logic [7:0]  REG_SUMMARY  = 8'h28;
  localparam logic [7:0]  REG_CTRL     = 8'h29;
  localparam logic [7:0]  REG_PHYCLK   = 8'h2A;
  localparam logic [7:0]  REG_GLOBAL   = 8'h2B;
  localparam logic [15:0] FREE_RESET   = 16'h0200;
  localparam int          B_TXFE       = 7;
  localparam int          B_NAKEFF     = 6;
  localparam int          B_B2B        = 6;
  localparam int          B_TOKEMPTY   = 4;
  localparam int          B_OUTDIS     = 4;
  localparam int          B_TIMEOUT    = 3;
  localparam int          B_SETUPDONE  = 3;
  localparam int          B_EPDIS      = 1;
  localparam int          B_XFERDONE   = 0;
  localparam int          B_STOPCLK    = 0;
  localparam int          B_SUSP       = 4;
  localparam logic [1:0]  SETUP_MAX    = 2'h3;

  typedef enum logic [1:0] {
    UES_PID_DATA0 = 2'b00,
    UES_PID_DATA2 = 2'b01,
    UES_PID_DATA1 = 2'b10,
    UES_PID_MDATA = 2'b11
  } ues_pid_e;

  // per-endpoint events from the core, one-cycle pulses
  typedef struct packed {
    logic nak_effect;
    logic in_tok_empty;
    logic timeout;
    logic disabled;
    logic xfer_done;
    logic pkt_from_fifo;
    logic pkt_to_fifo;
  } ues_in_ev_s;

  typedef struct packed {
    logic     setup_rx;
    logic     setup_end;
    logic     out_tok_dis;
    logic     disabled;
    logic     xfer_done;
    logic     pkt_to_fifo;
    logic     pkt_from_fifo;
    ues_pid_e pid;
  } ues_out_ev_s;
endpackage : ues_pkg

//--- src/ues_size_cnt.sv
// module: one transfer size register with packet and byte down-counters
`timescale 1ns/1ps
module ues_size_cnt
  import ues_pkg::*;
#(
  parameter int PW = 10,
  parameter int BW = 19
) (
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          wr_en,
  input  wire logic [31:0]   wr_data,
  input  wire logic          pkt_dec,
  input  wire logic          byte_dec,
  input  wire logic [BW-1:0] pkt_bytes,
  output logic      [PW-1:0] pkt_cnt,
  output logic      [BW-1:0] byte_cnt,
  output logic               byte_zero
);
  initial begin
    if (PW < 1 || PW > 10 || BW < 1 || BW > 19)
      $error("ues_size_cnt: width out of range");
  end

  logic [PW-1:0] pkt_r;
  logic [BW-1:0] byte_r;

  // packet count sits at bit 19 upward, byte count at bit 0
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pkt_r <= '0;
    end else if (wr_en) begin
      pkt_r <= wr_data[19 +: PW];
    end else if (pkt_dec && pkt_r != '0) begin
      pkt_r <= pkt_r - PW'(1);
    end
  end

  // saturates at zero so a short last packet cannot wrap the count
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      byte_r <= '0;
    end else if (wr_en) begin
      byte_r <= wr_data[BW-1:0];
    end else if (byte_dec) begin
      byte_r <= (pkt_bytes >= byte_r) ? '0 : byte_r - pkt_bytes;
    end
  end

  // pulse when count reaches zero by a decrement
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      byte_zero <= 1'b0;
    end else begin
      byte_zero <= byte_dec && !wr_en && byte_r != '0
                   && pkt_bytes >= byte_r;
    end
  end

  assign pkt_cnt  = pkt_r;
  assign byte_cnt = byte_r;

  chk_byte_zero_pulse: assert property (@(posedge CLK) disable iff (RST)
    byte_zero |-> byte_r == '0)
    else $error("zero pulse with nonzero byte count");
  chk_pkt_dec_step: assert property (@(posedge CLK) disable iff (RST)
    (pkt_dec && !wr_en && pkt_r != '0) |=> pkt_r == $past(pkt_r) - PW'(1))
    else $error("packet count did not step down");
endmodule : ues_size_cnt

//--- testbench/ues_core_model.sv
// core-side model: one-cycle endpoint event pulses toward the status block
`timescale 1ns/1ps
module ues_core_model
  import ues_pkg::*;
(
  input  wire logic         CLK,
  output ues_in_ev_s  [7:0] in_ev,
  output ues_out_ev_s [7:0] out_ev
);
  initial begin
    in_ev  = '0;
    out_ev = '0;
  end

  // each event stands for exactly one cycle, never stretched
  task automatic in_pulse(input int ep, input ues_in_ev_s ev);
    @(posedge CLK) in_ev[ep] <= ev;
    @(posedge CLK) in_ev[ep] <= '0;
  endtask : in_pulse

  task automatic out_pulse(input int ep, input ues_out_ev_s ev);
    @(posedge CLK) out_ev[ep] <= ev;
    @(posedge CLK) out_ev[ep] <= '0;
  endtask : out_pulse

  // the same event on n consecutive cycles, one packet per cycle
  task automatic out_train(input int ep, input ues_out_ev_s ev, input int n);
    repeat (n) @(posedge CLK) out_ev[ep] <= ev;
    @(posedge CLK) out_ev[ep] <= '0;
  endtask : out_train
endmodule : ues_core_model

//--- testbench/test_ues_ep_status.sv
// self-checking bench for the endpoint status block
`timescale 1ns/1ps
module test_ues_ep_status
  import ues_pkg::*;
;
  logic              clk, rst, wr_s, rd_s, rd_d, phy_susp, stop_clk;
  logic              gin, gout;
  logic [7:0]        addr, ep_en, ep_stall, clr_nak, ctrl_ep, bz_in, bz_out;
  logic [31:0]       wdata, rdata;
  logic [18:0]       pkt_bytes;
  logic [7:0][15:0]  fifo_free;
  logic [7:0][1:0]   ppf;
  ues_in_ev_s  [7:0] in_ev;
  ues_out_ev_s [7:0] out_ev;
  logic [31:0]       exp_q[$];
  int                mismatches, compares;
  int                ibit[5] = '{B_NAKEFF, B_TOKEMPTY, B_TIMEOUT, B_EPDIS,
                                 B_XFERDONE};
  int                obit[4] = '{B_SETUPDONE, B_OUTDIS, B_EPDIS, B_XFERDONE};
  logic [15:0]       fe[4] = '{16'h0100, 16'h00FF, 16'h0100, 16'h0200};
  logic [31:0]       fx[4] = '{32'h80, 32'h0, 32'h0, 32'h80};

  ues_core_model model_u (.CLK(clk), .in_ev(in_ev), .out_ev(out_ev));

  ues_ep_status dut_u (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .IN_EV(in_ev), .OUT_EV(out_ev), .EP_ENABLED(ep_en),
    .EP_STALL(ep_stall), .CLEAR_NAK(clr_nak), .CTRL_EP(ctrl_ep),
    .FIFO_FREE(fifo_free), .PKT_BYTES(pkt_bytes), .PHY_SUSPENDED(phy_susp),
    .BYTE_ZERO_IN(bz_in), .BYTE_ZERO_OUT(bz_out), .PACKETS_PER_FRAME(ppf),
    .STOP_PHY_CLOCK(stop_clk), .GLOBAL_IN_EVENT(gin), .GLOBAL_OUT_EVENT(gout)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test;
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
    end
    @(posedge clk) wr_s <= 1'b0;
  endtask : wr

  // the expectation is queued here and judged when the data appear
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin
      addr <= a;
      rd_s <= 1'b1;
    end
    exp_q.push_back(e);
    @(posedge clk) rd_s <= 1'b0;
  endtask : rd

  // the zero-count pulse is registered, so allow a few cycles only
  task automatic wait_zero(input bit out, input int ep);
    int n;
    for (n = 0; n < 4; n++) begin
      @(negedge clk);
      if ((out ? bz_out[ep] : bz_in[ep]) === 1'b1) break;
    end
    chk(32'(n < 4), 32'h1);
    if (n == 4) finish_test();
  endtask : wait_zero

  always @(posedge clk) rd_d <= rd_s;

  always @(negedge clk) begin
    if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
  end

  initial begin
    logic [9:0]  pk;
    logic [18:0] b;
    {rst, wr_s, rd_s, rd_d, phy_susp} = 5'h10;
    {addr, wdata, ep_en, ep_stall, clr_nak, pkt_bytes} = '0;
    ctrl_ep   = 8'h01;
    fifo_free = {8{16'h0200}};
    void'($urandom(32'h10A0));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(REG_FREE + 8'h01, 32'h200);
    fifo_free <= {8{16'h0080}};
    model_u.out_train(0, 9'h100, 3);
    rd(REG_OUTFLAG, 32'h0);
    model_u.out_pulse(0, 9'h100);
    rd(REG_OUTFLAG, 32'h40);
    wr(REG_OUTFLAG, 32'h40);
    for (int i = 0; i < 4; i++) begin
      model_u.out_pulse(0, ues_out_ev_s'(9'h080 >> i));
      rd(REG_OUTFLAG, 32'h1 << obit[i]);
      rd(REG_SUMMARY, 32'h10000);
      rd(REG_GLOBAL, 32'h2);
      chk({30'h0, gout, gin}, 32'h2);
      wr(REG_OUTFLAG, 32'h1 << obit[i]);
      rd(REG_OUTFLAG, 32'h0);
      rd(REG_SUMMARY, 32'h0);
      chk({30'h0, gout, gin}, 32'h0);
    end
    model_u.out_pulse(3, 9'h040);
    rd(REG_OUTFLAG + 8'h03, 32'h0);
    wr(REG_INSIZE, 32'h0010_0030);
    model_u.in_pulse(0, 7'h02);
    pkt_bytes <= 19'h30;
    model_u.in_pulse(0, 7'h01);
    wait_zero(1'b0, 0);
    rd(REG_INSIZE, 32'h0008_0000);
    model_u.out_train(6, 9'h100, 4);
    rd(REG_OUTFLAG + 8'h06, 32'h40);
    wr(REG_OUTFLAG + 8'h06, 32'h40);
    rd(REG_OUTFLAG + 8'h06, 32'h0);
    wr(REG_OUTSIZE, 32'h6008_0028);
    rd(REG_OUTSIZE, 32'h6008_0028);
    ep_en <= 8'h01;
    model_u.out_pulse(0, 9'h100);
    model_u.out_pulse(0, 9'h008);
    rd(REG_OUTSIZE, 32'h4000_0028);
    pkt_bytes <= 19'd40;
    model_u.out_pulse(0, 9'h004);
    wait_zero(1'b1, 0);
    rd(REG_OUTSIZE, 32'h4000_0000);
    for (int i = 0; i < 5; i++) begin
      model_u.in_pulse(0, ues_in_ev_s'(7'h40 >> i));
      rd(REG_INFLAG, 32'h1 << ibit[i]);
      rd(REG_SUMMARY, 32'h1);
      rd(REG_GLOBAL, 32'h1);
      chk({30'h0, gout, gin}, 32'h1);
      wr(REG_INFLAG, 32'h1 << ibit[i]);
      rd(REG_INFLAG, 32'h0);
    end
    model_u.in_pulse(0, 7'h40);
    clr_nak <= 8'h01;
    @(posedge clk) clr_nak <= 8'h00;
    rd(REG_INFLAG, 32'h0);
    model_u.in_pulse(3, 7'h10);
    rd(REG_INFLAG + 8'h03, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, 32'(i / 2));
      fifo_free[2] <= fe[i];
      rd(REG_INFLAG + 8'h02, fx[i]);
    end
    wr(REG_INFLAG + 8'h02, 32'h80);
    rd(REG_INFLAG + 8'h02, 32'h80);
    fifo_free[2] <= 16'h0080;
    pk = 10'($urandom_range(1023, 5));
    b  = 19'($urandom_range(524287, 1));
    wr(REG_INSIZE + 8'h03, {1'b0, 2'h2, pk, b});
    rd(REG_INSIZE + 8'h03, {1'b0, 2'h2, pk, b});
    chk({30'h0, ppf[3]}, 32'h2);
    ep_en <= 8'h09;
    wr(REG_INSIZE + 8'h03, 32'h0);
    rd(REG_INSIZE + 8'h03, {1'b0, 2'h2, pk, b});
    model_u.in_pulse(3, 7'h02);
    pkt_bytes <= b;
    model_u.in_pulse(3, 7'h01);
    wait_zero(1'b0, 3);
    rd(REG_INSIZE + 8'h03, {1'b0, 2'h2, pk - 10'h1, 19'h0});
    wr(REG_OUTSIZE + 8'h05, {3'h0, pk, b});
    ep_en <= 8'h29;
    for (int j = 0; j < 4; j++) begin
      model_u.out_pulse(5, ues_out_ev_s'(9'h008 | 9'(j)));
      rd(REG_OUTSIZE + 8'h05, {1'b0, 2'(j), pk - 10'(j + 1), b});
    end
    model_u.out_pulse(5, 9'h004);
    wait_zero(1'b1, 5);
    rd(REG_OUTSIZE + 8'h05, {1'b0, 2'h3, pk - 10'h4, 19'h0});
    wr(REG_PHYCLK, 32'h1);
    phy_susp <= 1'b1;
    rd(REG_PHYCLK, 32'h11);
    chk({31'h0, stop_clk}, 32'h1);
    rd(8'hFF, 32'h0);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule : test_ues_ep_status
